// >>> rtl/mmc_defines.svh
// constants for the monitor mask and configuration register bank
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH
// register indices; byte address is four times the index
`define MMC_IDX_AMB_FAN 8'h13
`define MMC_IDX_REM_FAN 8'h14
`define MMC_IDX_STATUS2 8'h42
`define MMC_IDX_MASK2 8'h44
`define MMC_IDX_INTR_CLR 8'h46
`define MMC_IDX_VID_FAN 8'h47
`define MMC_IDX_VID_MSB 8'h49
`define MMC_IDX_CONFIG2 8'h4a
// field positions
`define MMC_INTR_CLR_BIT 7
`define MMC_STAT_INTR_BIT 4
`define MMC_STAT_OVERTEMP_SIGNAL_BIT 5
`define MMC_CFG_OVERTEMP_SIGNAL_MASK 0
`define MMC_CFG_LOCK_AMB 1
`define MMC_CFG_LOCK_REM 2
`define MMC_CFG_ACPI 3
`define MMC_FAN_A_LSB 4
`define MMC_FAN_B_LSB 6
// reset values and implemented-bit masks
`define MMC_RST_MASK2 8'h00
`define MMC_RST_CONFIG2 8'h00
`define MMC_RST_FAN_DIV 4'h0
`define MMC_STAT2_IMPL 8'hf3
`define MMC_CFG2_IMPL 8'h0f
// timing
`define MMC_CLK_MHZ 100
`define MMC_INTR_PULSE_MS 20
`define MMC_INTR_PULSE_CYC (`MMC_INTR_PULSE_MS * 1000 * `MMC_CLK_MHZ)
`endif

// >>> rtl/mmc_pkg.sv
// types shared by the monitor mask and configuration register bank
package mmc_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mmc_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mmc_wb_rsp_t;
  typedef enum logic {MMC_PT_IDLE, MMC_PT_RUN} mmc_pt_state_t;
endpackage

// >>> rtl/mmc_pulse_timer.sv
// one-shot timer holding busy for a fixed number of clock cycles
module mmc_pulse_timer #(
  parameter logic [20:0] LEN = 21'd2000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // control
  input wire logic start,
  output logic busy
);
  import mmc_pkg::*;

  mmc_pt_state_t state_r;
  logic [20:0] cnt_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= MMC_PT_IDLE;
      cnt_r <= 21'h0;
    end else if (soft_rst) begin
      state_r <= MMC_PT_IDLE;
      cnt_r <= 21'h0;
    end else begin
      unique case (state_r)
        MMC_PT_IDLE: begin
          if (start) begin
            state_r <= MMC_PT_RUN;
            cnt_r <= LEN - 21'd1;
          end
        end
        MMC_PT_RUN: begin
          if (cnt_r == 21'h0) begin
            state_r <= MMC_PT_IDLE;
          end else begin
            cnt_r <= cnt_r - 21'd1;
          end
        end
      endcase
    end
  end

  assign busy = (state_r == MMC_PT_RUN);
endmodule // mmc_pulse_timer

// >>> rtl/mmc_regs.sv
// mask, intrusion clear, voltage code, fan prescale and config 2 registers
//
// Our own choice: the Wishbone interface to the registers.
`include "mmc_defines.svh"
module mmc_regs #(
  parameter logic [20:0] INTR_PULSE_CYC = 21'(`MMC_INTR_PULSE_CYC),
  parameter logic [6:0] IDENT_CODE = 7'h2a // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic soft_rst,
  // classic wishbone slave
  input wire mmc_pkg::mmc_wb_req_t wb_req,
  output mmc_pkg::mmc_wb_rsp_t wb_rsp,
  // status sources
  input wire logic [7:0] stat2_cond,
  input wire logic bank1_irq_req,
  input wire logic temp_irq_req,
  input wire logic temp_over,
  // voltage code pins
  input wire logic [3:0] cpu_voltage_code,
  input wire logic cpu_voltage_code_msb,
  // intrusion pin, open drain
  input wire logic intr_pin_in,
  output logic intr_pin_out,
  output logic intr_pin_oe,
  // overtemp pin, open drain
  input wire logic overtemp_signal_in,
  output logic overtemp_signal_out,
  output logic overtemp_signal_oe,
  output logic overtemp_acpi_mode,
  // fan tach prescalers
  input wire logic [1:0] fan_tach_pulse,
  output logic [1:0] fan_tach_tick,
  // fan control register write strobes
  output logic fan_amb_we,
  output logic fan_rem_we,
  output logic [7:0] fan_wdat,
  output logic lock_amb,
  output logic lock_rem,
  // interrupt
  output logic int_n
);
  import mmc_pkg::*;

  logic ack_r;
  logic [7:0] rdat_r;
  logic [7:0] mask2_r;
  logic [7:0] stat2_r;
  logic [7:0] config2_r;
  logic [3:0] fan_div_r;
  logic [7:0] fan_wdat_r;
  logic fan_amb_we_r;
  logic fan_rem_we_r;
  logic int_n_r;
  logic otemp_oe_r;
  logic [7:0] rd_mux;
  logic [7:0] idx;
  logic take;
  logic wr;
  logic rd;
  logic pulse_busy;
  logic pulse_start;
  logic [7:0] stat2_set;
  logic [7:0] stat2_clr;
  logic [7:0] irq_gate;
  logic irq_any;

  // one-word decode; upper address bits must be zero, byte lane 0 carries data
  assign idx = wb_req.adr[9:2];
  assign take = wb_req.cyc && wb_req.stb && !ack_r && (wb_req.adr[11:10] == 2'b00)
    && (wb_req.adr[1:0] == 2'b00);
  assign wr = take && wb_req.we && wb_req.sel[0];
  assign rd = take && !wb_req.we;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req.cyc && wb_req.stb && !ack_r;
    end
  end

  // read mux; unmapped indices answer zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      `MMC_IDX_STATUS2: rd_mux = stat2_r;
      `MMC_IDX_MASK2: rd_mux = mask2_r;
      `MMC_IDX_INTR_CLR: rd_mux = {pulse_busy, 7'h00};
      `MMC_IDX_VID_FAN: rd_mux = {fan_div_r, cpu_voltage_code};
      `MMC_IDX_VID_MSB: rd_mux = {IDENT_CODE, cpu_voltage_code_msb};
      `MMC_IDX_CONFIG2: rd_mux = config2_r & `MMC_CFG2_IMPL;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdat_r <= 8'h00;
    end else if (rd) begin
      rdat_r <= rd_mux;
    end
  end

  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = {24'h000000, rdat_r};

  // mask register 2; reserved bits 2 and 3 are plain storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask2_r <= `MMC_RST_MASK2;
    end else if (soft_rst) begin
      mask2_r <= `MMC_RST_MASK2;
    end else if (wr && idx == `MMC_IDX_MASK2) begin
      mask2_r <= wb_req.dat[7:0];
    end
  end

  // status 2: set from live conditions, cleared by a read, set wins
  always_comb begin
    stat2_set = stat2_cond & `MMC_STAT2_IMPL;
    stat2_set[`MMC_STAT_INTR_BIT] = stat2_cond[`MMC_STAT_INTR_BIT]
      | (intr_pin_in & !intr_pin_oe);
    stat2_set[`MMC_STAT_OVERTEMP_SIGNAL_BIT] = stat2_cond[`MMC_STAT_OVERTEMP_SIGNAL_BIT]
      | (!overtemp_signal_in & !overtemp_signal_oe);
    stat2_clr = (rd && idx == `MMC_IDX_STATUS2) ? 8'hff : 8'h00;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat2_r <= 8'h00;
    end else if (soft_rst) begin
      stat2_r <= 8'h00;
    end else begin
      stat2_r <= (stat2_r & ~stat2_clr) | stat2_set;
    end
  end

  // intrusion clear pulse; a write during a pulse does not restart it
  assign pulse_start = wr && idx == `MMC_IDX_INTR_CLR && wb_req.dat[`MMC_INTR_CLR_BIT];

  mmc_pulse_timer #(
    .LEN(INTR_PULSE_CYC)
  ) u_intr_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .start(pulse_start),
    .busy(pulse_busy)
  );

  assign intr_pin_out = 1'b0;
  assign intr_pin_oe = pulse_busy;

  // fan prescale and config 2
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fan_div_r <= `MMC_RST_FAN_DIV;
    end else if (soft_rst) begin
      fan_div_r <= `MMC_RST_FAN_DIV;
    end else if (wr && idx == `MMC_IDX_VID_FAN) begin
      fan_div_r <= wb_req.dat[7:4];
    end
  end

  // lock bits only ever set by a write; reset or soft reset releases them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config2_r <= `MMC_RST_CONFIG2;
    end else if (soft_rst) begin
      config2_r <= `MMC_RST_CONFIG2;
    end else if (wr && idx == `MMC_IDX_CONFIG2) begin
      config2_r[`MMC_CFG_OVERTEMP_SIGNAL_MASK] <= wb_req.dat[`MMC_CFG_OVERTEMP_SIGNAL_MASK];
      config2_r[`MMC_CFG_ACPI] <= wb_req.dat[`MMC_CFG_ACPI];
      config2_r[`MMC_CFG_LOCK_AMB] <= config2_r[`MMC_CFG_LOCK_AMB]
        | wb_req.dat[`MMC_CFG_LOCK_AMB];
      config2_r[`MMC_CFG_LOCK_REM] <= config2_r[`MMC_CFG_LOCK_REM]
        | wb_req.dat[`MMC_CFG_LOCK_REM];
    end
  end

  assign lock_amb = config2_r[`MMC_CFG_LOCK_AMB];
  assign lock_rem = config2_r[`MMC_CFG_LOCK_REM];
  assign overtemp_acpi_mode = config2_r[`MMC_CFG_ACPI];

  // write strobes to the fan control registers, held off while locked
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fan_amb_we_r <= 1'b0;
      fan_rem_we_r <= 1'b0;
      fan_wdat_r <= 8'h00;
    end else begin
      fan_amb_we_r <= wr && idx == `MMC_IDX_AMB_FAN && !lock_amb;
      fan_rem_we_r <= wr && idx == `MMC_IDX_REM_FAN && !lock_rem;
      if (wr) begin
        fan_wdat_r <= wb_req.dat[7:0];
      end
    end
  end

  assign fan_amb_we = fan_amb_we_r;
  assign fan_rem_we = fan_rem_we_r;
  assign fan_wdat = fan_wdat_r;

  // tach prescalers: one tick per 1, 2, 4 or 8 tach pulses
  for (genvar g = 0; g < 2; g++) begin : g_fan
    logic [2:0] cnt_r;
    logic [2:0] top;
    logic tick_r;
    assign top = 3'((4'h1 << fan_div_r[2*g +: 2]) - 4'h1);
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        cnt_r <= 3'h0;
        tick_r <= 1'b0;
      end else begin
        tick_r <= 1'b0;
        if (fan_tach_pulse[g]) begin
          if (cnt_r >= top) begin
            cnt_r <= 3'h0;
            tick_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 3'h1;
          end
        end
      end
    end
    assign fan_tach_tick[g] = tick_r;
  end

  // interrupt: thermal mask gates the interrupt path only
  always_comb begin
    irq_gate = ~mask2_r & `MMC_STAT2_IMPL;
    irq_gate[`MMC_STAT_OVERTEMP_SIGNAL_BIT] = irq_gate[`MMC_STAT_OVERTEMP_SIGNAL_BIT]
      & !config2_r[`MMC_CFG_OVERTEMP_SIGNAL_MASK];
    irq_any = |(stat2_r & irq_gate) | bank1_irq_req
      | (temp_irq_req & !config2_r[`MMC_CFG_OVERTEMP_SIGNAL_MASK]);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_n_r <= 1'b1;
      otemp_oe_r <= 1'b0;
    end else begin
      int_n_r <= !irq_any;
      otemp_oe_r <= temp_over;
    end
  end

  assign int_n = int_n_r;
  assign overtemp_signal_out = 1'b0;
  assign overtemp_signal_oe = otemp_oe_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  int unsigned low_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= intr_pin_oe ? low_cnt + 1 : 0;
    end
  end

  sequence s_clr_write;
    pulse_start && !pulse_busy && !soft_rst;
  endsequence
  sequence s_pulse_hold;
    (intr_pin_oe && !soft_rst) [*8];
  endsequence

  chk_pulse_start: assert property (s_clr_write |=> s_pulse_hold or ##[0:7] soft_rst)
    else $error("intrusion pulse did not start");
  // low_cnt has counted every sampled high cycle by the edge that sees the fall
  chk_pulse_length: assert property ($fell(intr_pin_oe) && !$past(soft_rst)
    |-> low_cnt >= INTR_PULSE_CYC)
    else $error("intrusion pulse too short");
  chk_clr_selfclear: assert property (rd && idx == `MMC_IDX_INTR_CLR && !intr_pin_oe
    |=> rdat_r[7] == 1'b0)
    else $error("intrusion clear bit stuck");
  chk_intr_reserved: assert property (rd && idx == `MMC_IDX_INTR_CLR |=> rdat_r[6:0] == 7'h00)
    else $error("intrusion clear reserved bits not zero");
  chk_vid_live: assert property (rd && idx == `MMC_IDX_VID_FAN
    |=> rdat_r[3:0] == $past(cpu_voltage_code))
    else $error("voltage code not live");
  chk_fan_a_div1: assert property (fan_div_r[1:0] == 2'b00 && fan_tach_pulse[0]
    |=> fan_tach_tick[0])
    else $error("fan a divide by one missed tick");
  chk_fan_b_div8: assert property (fan_div_r[3:2] == 2'b11 && $rose(fan_tach_tick[1])
    |=> !fan_tach_tick[1])
    else $error("fan b divide by eight ticked twice");
  chk_vid_msb: assert property (rd && idx == `MMC_IDX_VID_MSB
    |=> rdat_r[0] == $past(cpu_voltage_code_msb))
    else $error("voltage code msb wrong");
  chk_overtemp_signal_mask: assert property (config2_r[0] && !bank1_irq_req
    && (stat2_r & ~mask2_r & 8'hd3) == 8'h00 |=> int_n)
    else $error("thermal source reached interrupt while masked");
  chk_overtemp_free: assert property (temp_over |=> overtemp_signal_oe)
    else $error("overtemp output not asserted");
  chk_lock_amb: assert property (lock_amb && wr && idx == `MMC_IDX_AMB_FAN |=> !fan_amb_we)
    else $error("ambient fan write passed lock");
  chk_lock_rem: assert property (lock_rem && wr && idx == `MMC_IDX_REM_FAN |=> !fan_rem_we)
    else $error("remote fan write passed lock");
  chk_lock_hold: assert property (lock_amb && !soft_rst |=> lock_amb)
    else $error("ambient lock released without reset");
  chk_acpi_mode: assert property (wr && idx == `MMC_IDX_CONFIG2 && !soft_rst
    |=> overtemp_acpi_mode == $past(wb_req.dat[3]))
    else $error("overtemp mode not taken");
  chk_stat_rdclr: assert property (rd && idx == `MMC_IDX_STATUS2 && stat2_set == 8'h00
    && !soft_rst |=> stat2_r == 8'h00)
    else $error("status not cleared by read");
  chk_irq_level: assert property (irq_any |=> !int_n)
    else $error("interrupt not asserted");
endmodule // mmc_regs

// >>> tb/mmc_regs_bench.sv
// self-checking bench for the monitor mask and configuration register bank
module mmc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import mmc_pkg::*;
  localparam logic [20:0] PULSE = 21'd20;
  localparam logic [6:0] IDENT = 7'h15; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_rst = 1'b0;
  mmc_wb_req_t wb_req = '0;
  mmc_wb_rsp_t wb_rsp;
  logic [7:0] stat2_cond = 8'h00;
  logic bank1_irq_req = 1'b0;
  logic temp_irq_req = 1'b0;
  logic temp_over = 1'b0;
  logic [3:0] cpu_voltage_code = 4'h0;
  logic cpu_voltage_code_msb = 1'b0;
  logic intr_lvl = 1'b0;
  logic ot_lvl = 1'b1;
  logic [1:0] fan_tach_pulse = 2'b00;
  logic intr_pin_in, intr_pin_out, intr_pin_oe;
  logic overtemp_signal_in, overtemp_signal_out, overtemp_signal_oe, overtemp_acpi_mode;
  logic [1:0] fan_tach_tick;
  logic fan_amb_we, fan_rem_we, lock_amb, lock_rem, int_n;
  logic [7:0] fan_wdat;
  logic [7:0] rd, oe_n, amb_n, rem_n, last_wd, tick_a, tick_b;
  int err_total = 0;
  int num_checks = 0;
  int cyc_n = 0;
  int srcs[6] = '{0, 1, 4, 5, 6, 7};

  // open drain pins: our own driver wins, else the outside level
  assign intr_pin_in = intr_pin_oe ? intr_pin_out : intr_lvl;
  assign overtemp_signal_in = overtemp_signal_oe ? overtemp_signal_out : ot_lvl;

  mmc_regs #(.INTR_PULSE_CYC(PULSE), .IDENT_CODE(IDENT)) mmc_regs_i (
    .sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst),
    .wb_req(wb_req), .wb_rsp(wb_rsp),
    .stat2_cond(stat2_cond), .bank1_irq_req(bank1_irq_req),
    .temp_irq_req(temp_irq_req), .temp_over(temp_over),
    .cpu_voltage_code(cpu_voltage_code), .cpu_voltage_code_msb(cpu_voltage_code_msb),
    .intr_pin_in(intr_pin_in), .intr_pin_out(intr_pin_out), .intr_pin_oe(intr_pin_oe),
    .overtemp_signal_in(overtemp_signal_in), .overtemp_signal_out(overtemp_signal_out),
    .overtemp_signal_oe(overtemp_signal_oe), .overtemp_acpi_mode(overtemp_acpi_mode),
    .fan_tach_pulse(fan_tach_pulse), .fan_tach_tick(fan_tach_tick),
    .fan_amb_we(fan_amb_we), .fan_rem_we(fan_rem_we), .fan_wdat(fan_wdat),
    .lock_amb(lock_amb), .lock_rem(lock_rem), .int_n(int_n)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one-cycle outputs counted mid-cycle, settled and clear of the bus tasks' edges
  always @(negedge sys_clk) begin
    cyc_n++;
    if (fan_amb_we === 1'b1) amb_n++;
    if (fan_rem_we === 1'b1) rem_n++;
    if ((fan_amb_we | fan_rem_we) === 1'b1) last_wd = fan_wdat;
    if (fan_tach_tick[0] === 1'b1) tick_a++;
    if (fan_tach_tick[1] === 1'b1) tick_b++;
    if (intr_pin_oe === 1'b1) oe_n++;
    if (intr_pin_oe === 1'b1 && intr_pin_out !== 1'b0) begin
      err_total++;
      $display("[ERR] %0t intrusion pin driven high", $time);
    end
    if (cyc_n > 10000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic [11:0] adr, input logic we, input logic [7:0] wd,
                    output logic [7:0] rdat);
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
    do @(posedge sys_clk); while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb({2'b00, idx, 2'b00}, 1'b1, d, rd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    wb({2'b00, idx, 2'b00}, 1'b0, 8'h00, rd);
    check(rd, exp, "read");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic src(input int b, input logic v);
    @(posedge sys_clk);
    if (b == 4) intr_lvl <= v;
    else if (b == 5) ot_lvl <= !v;
    else stat2_cond[b] <= v;
  endtask

  initial begin
    {oe_n, amb_n, rem_n, last_wd, tick_a, tick_b} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    idle(2);
    rdc(8'h44, 8'h00);
    rdc(8'h46, 8'h00);
    rdc(8'h4a, 8'h00);
    wb(12'h111, 1'b0, 8'h00, rd);
    check(rd, 8'h00, "unmapped");
    foreach (srcs[i]) begin
      src(srcs[i], 1'b1);
      idle(3);
      check({7'h0, int_n}, 8'h00, "int low");
      wr(8'h44, 8'h01 << srcs[i]);
      idle(3);
      check({7'h0, int_n}, 8'h01, "int masked");
      rdc(8'h44, 8'h01 << srcs[i]);
      rdc(8'h42, 8'h01 << srcs[i]);
      src(srcs[i], 1'b0);
      rdc(8'h42, 8'h01 << srcs[i]);
      rdc(8'h42, 8'h00);
      wr(8'h44, 8'h00);
    end
    @(posedge sys_clk);
    bank1_irq_req <= 1'b1;
    idle(3);
    check({7'h0, int_n}, 8'h00, "bank1 int");
    bank1_irq_req <= 1'b0;
    temp_irq_req <= 1'b1;
    idle(3);
    check({7'h0, int_n}, 8'h00, "temp int");
    wr(8'h4a, 8'h01);
    src(5, 1'b1);
    idle(3);
    check({7'h0, int_n}, 8'h01, "thermal masked");
    temp_over <= 1'b1;
    idle(3);
    check({7'h0, overtemp_signal_oe}, 8'h01, "overtemp out");
    temp_over <= 1'b0;
    temp_irq_req <= 1'b0;
    src(5, 1'b0);
    idle(3);
    wb(12'h108, 1'b0, 8'h00, rd);
    wr(8'h4a, 8'h00);
    oe_n = 0;
    wr(8'h46, 8'h80);
    rdc(8'h46, 8'h80);
    wr(8'h46, 8'h80);
    idle(30);
    check(oe_n, 8'(PULSE), "pulse length");
    rdc(8'h46, 8'h00);
    wr(8'h46, 8'h7f);
    rdc(8'h46, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      cpu_voltage_code <= k[0] ? 4'ha : 4'h5;
      cpu_voltage_code_msb <= k[0];
      idle(2);
      rdc(8'h47, {4'h0, k[0] ? 4'ha : 4'h5});
      rdc(8'h49, {IDENT, k[0]});
    end
    // every divisor divides 8, so each block leaves the prescalers at zero
    for (int d = 0; d < 4; d++) begin
      wr(8'h47, {2'(3 - d), 2'(d), 4'h0});
      rdc(8'h47, {2'(3 - d), 2'(d), 4'ha});
      tick_a = 0;
      tick_b = 0;
      repeat (8) begin
        @(posedge sys_clk);
        fan_tach_pulse <= 2'b11;
        @(posedge sys_clk);
        fan_tach_pulse <= 2'b00;
      end
      idle(3);
      check(tick_a, 8'(8 >> d), "fan a ticks");
      check(tick_b, 8'(8 >> (3 - d)), "fan b ticks");
    end
    wr(8'h13, 8'h5a);
    check(amb_n, 8'h01, "amb strobe");
    check(last_wd, 8'h5a, "fan data");
    wr(8'h4a, 8'h0e);
    rdc(8'h4a, 8'h0e);
    check({6'h0, lock_rem, lock_amb, overtemp_acpi_mode}, 8'h07, "locks acpi");
    wr(8'h13, 8'h11);
    wr(8'h14, 8'h22);
    check(amb_n, 8'h01, "amb locked");
    check(rem_n, 8'h00, "rem locked");
    wr(8'h4a, 8'hf0);
    rdc(8'h4a, 8'h06);
    check({7'h0, overtemp_acpi_mode}, 8'h00, "acpi off");
    @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    idle(1);
    rdc(8'h4a, 8'h00);
    wr(8'h14, 8'h33);
    check(rem_n, 8'h01, "rem unlocked");
    check(last_wd, 8'h33, "fan data");
    end_of_test();
  end
endmodule // mmc_regs_bench
